// ### rtl/status_pin_source_select.sv
// Status pin B source selection, polarity, register port and interrupt.
// How it works
// - Selector in bits 7:4 of the control register, reset code 0x2.
// - Codes 0 and 1 show primary or secondary reference loss of signal.
// - Code 2 shows synthesizer A loss of lock, code 5 synthesizer B.
// - Codes 3 and 6 show halved reference divider when not bypassed.
// - Codes 4 and 7 show halved feedback divider of A or B.
// - Codes 0xB and 0xC show halved M divider when not bypassed.
// - Codes 8 and 9 show VCO calibration in progress for A or B.
// - 0xA interrupt summary, 0xD EEPROM busy, 0xE/0xF input switch events.
// - Interrupt summary is the OR of unmasked interrupt flag bits.
// - Bit 3 sets polarity, reset 1: one is active high, zero low.
// - Active test configuration overrides the normal source selection.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module status_pin_source_select (
	// Clock and reset
	input  wire logic                                clk_sys_in,
	input  wire logic                                nrst_in,
	// Register port
	input  wire logic [7:0]                          reg_addr_in,
	input  wire logic [7:0]                          reg_wdata_in,
	input  wire logic                                reg_wr_in,
	input  wire logic                                reg_rd_in,
	output logic      [7:0]                          reg_rdata_out,
	// Monitored conditions
	input  wire logic                                primary_reference_input_los_in,
	input  wire logic                                secondary_reference_input_los_in,
	input  wire logic                                synthesizer_a_loss_of_lock_in,
	input  wire logic                                synthesizer_b_loss_of_lock_in,
	input  wire logic                                synthesizer_a_cal_in,
	input  wire logic                                synthesizer_b_cal_in,
	input  wire logic                                eeprom_active_in,
	input  wire logic                                synthesizer_a_switch_in,
	input  wire logic                                synthesizer_b_switch_in,
	// Divider pulses and bypass states
	input  wire logic [status_pin_pkg::NUM_DIV-1:0]  div_pulse_in,
	input  wire logic [status_pin_pkg::NUM_DIV-1:0]  div_bypass_in,
	// Interrupt flag sources
	input  wire logic [status_pin_pkg::FLAG_W-1:0]   int_flag_set_in,
	// Status pin and interrupt
	output logic                                     status_pin_b_out,
	output logic                                     irq_out
);
	// Register fields, read data and pin state.
	logic [3:0] status_pin1_source_select_q;
	logic       status_pin1_polarity_q;
	logic [1:0] test_ctrl_q;
	logic [status_pin_pkg::FLAG_W-1:0]  int_flag_q;
	logic [status_pin_pkg::FLAG_W-1:0]  int_flag_mask_q;
	logic [status_pin_pkg::NUM_IRQ-1:0] irq_status_q;
	logic [status_pin_pkg::NUM_IRQ-1:0] irq_mask_q;
	logic [7:0] rdata_q;
	logic       pin_q;
	logic       pin_prev_q;
	logic       summary_prev_q;

	// One address compare serves both the write enables and the read mux.
	function automatic logic reg_hit(input logic [7:0] bus_addr,
		input logic [7:0] map_addr);
		reg_hit = bus_addr == map_addr;
	endfunction

	// Address decode.
	wire hit_ctrl  =
		reg_hit(reg_addr_in, status_pin_pkg::STATUS_PIN1_CONTROL_ADDR);
	wire hit_ists  =
		reg_hit(reg_addr_in, status_pin_pkg::IRQ_STATUS_ADDR);
	wire hit_imsk  =
		reg_hit(reg_addr_in, status_pin_pkg::IRQ_MASK_ADDR);
	wire hit_flag  =
		reg_hit(reg_addr_in, status_pin_pkg::INT_FLAG_ADDR);
	wire hit_fmsk  =
		reg_hit(reg_addr_in, status_pin_pkg::INT_FLAG_MASK_ADDR);
	wire hit_test  =
		reg_hit(reg_addr_in, status_pin_pkg::TEST_CTRL_ADDR);
	wire wr_ctrl   = reg_wr_in & hit_ctrl;
	wire wr_ists   = reg_wr_in & hit_ists;
	wire wr_imsk   = reg_wr_in & hit_imsk;
	wire wr_flag   = reg_wr_in & hit_flag;
	wire wr_fmsk   = reg_wr_in & hit_fmsk;
	wire wr_test   = reg_wr_in & hit_test;

	// Register fields as they arrive on the write data.
	wire [3:0] wr_sel = reg_wdata_in[
		status_pin_pkg::SEL_MSB:status_pin_pkg::SEL_LSB];
	wire       wr_pol = reg_wdata_in[status_pin_pkg::POL_BIT];
	wire [1:0] wr_tst = {reg_wdata_in[status_pin_pkg::TEST_VAL_BIT],
		reg_wdata_in[status_pin_pkg::TEST_EN_BIT]};

	// Interrupt summary from the flag register.
	wire interrupt_summary = |(int_flag_q & int_flag_mask_q);

	// Halved divider taps.
	logic [status_pin_pkg::NUM_DIV-1:0] div_half;
	status_pin_halver u_halver (
		.clk_sys_in   (clk_sys_in),
		.nrst_in      (nrst_in),
		.div_pulse_in (div_pulse_in),
		.div_half_out (div_half)
	);

	// A bypassed divider has no meaningful halved tap, so it reads low; the N taps take div_half and skip this.
	wire [status_pin_pkg::NUM_DIV-1:0] div_tap = div_half & ~div_bypass_in;

	// Source vector indexed by selector code.
	logic [status_pin_pkg::NUM_SRC-1:0] src;
	assign src[status_pin_pkg::SRC_PRI_LOS] =
		primary_reference_input_los_in;
	assign src[status_pin_pkg::SRC_SEC_LOS] =
		secondary_reference_input_los_in;
	assign src[status_pin_pkg::SRC_A_LOL] =
		synthesizer_a_loss_of_lock_in;
	assign src[status_pin_pkg::SRC_B_LOL] =
		synthesizer_b_loss_of_lock_in;
	assign src[status_pin_pkg::SRC_A_RDIV] =
		div_tap[status_pin_pkg::DIV_A_R];
	assign src[status_pin_pkg::SRC_B_RDIV] =
		div_tap[status_pin_pkg::DIV_B_R];
	assign src[status_pin_pkg::SRC_A_NDIV] =
		div_half[status_pin_pkg::DIV_A_N];
	assign src[status_pin_pkg::SRC_B_NDIV] =
		div_half[status_pin_pkg::DIV_B_N];
	assign src[status_pin_pkg::SRC_A_MDIV] =
		div_tap[status_pin_pkg::DIV_A_M];
	assign src[status_pin_pkg::SRC_B_MDIV] =
		div_tap[status_pin_pkg::DIV_B_M];
	assign src[status_pin_pkg::SRC_A_CAL] = synthesizer_a_cal_in;
	assign src[status_pin_pkg::SRC_B_CAL] = synthesizer_b_cal_in;
	assign src[status_pin_pkg::SRC_INTERRUPT_SUMMARY] = interrupt_summary;
	assign src[status_pin_pkg::SRC_EEPROM] = eeprom_active_in;
	assign src[status_pin_pkg::SRC_A_SWITCH] =
		synthesizer_a_switch_in;
	assign src[status_pin_pkg::SRC_B_SWITCH] =
		synthesizer_b_switch_in;

	logic selected;
	status_pin_selector u_selector (
		.sel_in    (status_pin1_source_select_q),
		.src_in    (src),
		.level_out (selected)
	);

	// Test override, then polarity.
	wire test_en = test_ctrl_q[status_pin_pkg::TEST_EN_BIT];
	wire test_val = test_ctrl_q[status_pin_pkg::TEST_VAL_BIT];
	wire pin_d = test_en ? test_val :
		(status_pin1_polarity_q ? selected : ~selected);

	// Interrupt events.
	logic [status_pin_pkg::NUM_IRQ-1:0] irq_event;
	assign irq_event[status_pin_pkg::IRQ_WRITE_BIT] = wr_ctrl;
	assign irq_event[status_pin_pkg::IRQ_PIN_RISE] = pin_q & ~pin_prev_q;
	assign irq_event[status_pin_pkg::IRQ_PIN_FALL] = ~pin_q & pin_prev_q;
	assign irq_event[status_pin_pkg::IRQ_FLAG_RISE] =
		interrupt_summary & ~summary_prev_q;

	// Write-one-to-clear masks, zero unless that register is written.
	wire [status_pin_pkg::NUM_IRQ-1:0] irq_clr =
		wr_ists ? reg_wdata_in[status_pin_pkg::NUM_IRQ-1:0] : '0;
	wire [status_pin_pkg::FLAG_W-1:0]  flag_clr =
		wr_flag ? reg_wdata_in : '0;

	// Set wins over a write-one clear in the same cycle.
	wire [status_pin_pkg::NUM_IRQ-1:0] irq_status_d =
		irq_event | (irq_status_q & ~irq_clr);
	wire [status_pin_pkg::FLAG_W-1:0]  int_flag_d =
		int_flag_set_in | (int_flag_q & ~flag_clr);

	// Read mux; reserved bits read zero so software need not mask them.
	wire [7:0] ctrl_rd = {status_pin1_source_select_q,
		status_pin1_polarity_q, 3'h0};
	wire [7:0] rd_mux =
		hit_ctrl ? ctrl_rd :
		hit_ists ? {4'h0, irq_status_q} :
		hit_imsk ? {4'h0, irq_mask_q} :
		hit_flag ? int_flag_q :
		hit_fmsk ? int_flag_mask_q :
		hit_test ? {6'h00, test_ctrl_q} :
		status_pin_pkg::RD_ZERO;

	// Read data stand for one cycle only, so an idle bus reads zero.
	wire [7:0] rdata_d = reg_rd_in ? rd_mux : status_pin_pkg::RD_ZERO;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_pin1_source_select_q <= status_pin_pkg::SEL_RESET;
			status_pin1_polarity_q <= status_pin_pkg::POL_RESET;
		end else if (wr_ctrl) begin
			status_pin1_source_select_q <= wr_sel;
			status_pin1_polarity_q <= wr_pol;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			test_ctrl_q <= 2'h0;
		end else if (wr_test) begin
			test_ctrl_q <= wr_tst;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_mask_q <= '0;
		end else if (wr_imsk) begin
			irq_mask_q <= reg_wdata_in[status_pin_pkg::NUM_IRQ-1:0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			int_flag_mask_q <= '0;
		end else if (wr_fmsk) begin
			int_flag_mask_q <= reg_wdata_in;
		end
	end

	// Sticky bits; the next values already let a set beat a clear.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_status_q <= '0;
			int_flag_q <= '0;
		end else begin
			irq_status_q <= irq_status_d;
			int_flag_q <= int_flag_d;
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_q <= status_pin_pkg::RD_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Registering the pin costs one cycle but keeps it glitch free.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_d;
		end
	end

	// Edge history for the pin and summary interrupt events.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_prev_q <= 1'b0;
			summary_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_q;
			summary_prev_q <= interrupt_summary;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign status_pin_b_out = pin_q;
	assign irq_out = |(irq_status_q & irq_mask_q);
endmodule
`default_nettype wire

// ### inc/status_pin_pkg.sv
// Package with register map, field layout, reset values and source codes.
package status_pin_pkg;
	localparam logic [7:0] STATUS_PIN1_CONTROL_ADDR = 8'h1c;
	localparam logic [7:0] IRQ_STATUS_ADDR          = 8'h40;
	localparam logic [7:0] IRQ_MASK_ADDR            = 8'h44;
	localparam logic [7:0] INT_FLAG_ADDR            = 8'h48;
	localparam logic [7:0] INT_FLAG_MASK_ADDR       = 8'h4c;
	localparam logic [7:0] TEST_CTRL_ADDR           = 8'h50;
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 4;
	localparam int POL_BIT = 3;
	localparam logic [3:0] SEL_RESET = 4'h2;
	localparam logic       POL_RESET = 1'b1;
	localparam int NUM_SRC   = 16;
	localparam int NUM_IRQ   = 4;
	localparam int FLAG_W    = 8;
	localparam int TEST_EN_BIT  = 0;
	localparam int TEST_VAL_BIT = 1;
	localparam int IRQ_WRITE_BIT   = 0;
	localparam int IRQ_PIN_RISE    = 1;
	localparam int IRQ_PIN_FALL    = 2;
	localparam int IRQ_FLAG_RISE   = 3;
	localparam logic [7:0] RD_ZERO = 8'h00;
	localparam logic [3:0] SRC_PRI_LOS     = 4'h0;
	localparam logic [3:0] SRC_SEC_LOS     = 4'h1;
	localparam logic [3:0] SRC_A_LOL       = 4'h2;
	localparam logic [3:0] SRC_A_RDIV      = 4'h3;
	localparam logic [3:0] SRC_A_NDIV      = 4'h4;
	localparam logic [3:0] SRC_B_LOL       = 4'h5;
	localparam logic [3:0] SRC_B_RDIV      = 4'h6;
	localparam logic [3:0] SRC_B_NDIV      = 4'h7;
	localparam logic [3:0] SRC_A_CAL       = 4'h8;
	localparam logic [3:0] SRC_B_CAL       = 4'h9;
	localparam logic [3:0] SRC_INTERRUPT_SUMMARY        = 4'ha;
	localparam logic [3:0] SRC_A_MDIV      = 4'hb;
	localparam logic [3:0] SRC_B_MDIV      = 4'hc;
	localparam logic [3:0] SRC_EEPROM      = 4'hd;
	localparam logic [3:0] SRC_A_SWITCH    = 4'he;
	localparam logic [3:0] SRC_B_SWITCH    = 4'hf;
	localparam int DIV_A_R = 0;
	localparam int DIV_A_N = 1;
	localparam int DIV_A_M = 2;
	localparam int DIV_B_R = 3;
	localparam int DIV_B_N = 4;
	localparam int DIV_B_M = 5;
	localparam int NUM_DIV = 6;
endpackage

// ### rtl/status_pin_halver.sv
// Divide-by-two toggles for the divider tap outputs.
`timescale 1ns/100ps
`default_nettype none
module status_pin_halver (
	// Clock and reset
	input  wire logic                                clk_sys_in,
	input  wire logic                                nrst_in,
	// Divider pulses and halved levels
	input  wire logic [status_pin_pkg::NUM_DIV-1:0]  div_pulse_in,
	output logic      [status_pin_pkg::NUM_DIV-1:0]  div_half_out
);
	logic [status_pin_pkg::NUM_DIV-1:0] half_q;
	logic [status_pin_pkg::NUM_DIV-1:0] half_d;

	genvar i;
	generate
		for (i = 0; i < status_pin_pkg::NUM_DIV; i = i + 1) begin : g_half
			// Toggling on each divider pulse gives a square wave at half rate.
			assign half_d[i] = half_q[i] ^ div_pulse_in[i];
		end
	endgenerate

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			half_q <= '0;
		end else begin
			half_q <= half_d;
		end
	end

	assign div_half_out = half_q;
endmodule
`default_nettype wire

// ### rtl/status_pin_selector.sv
// Sixteen-way source mux for the status pin.
`timescale 1ns/100ps
`default_nettype none
module status_pin_selector (
	// Selection
	input  wire logic [3:0]                             sel_in,
	input  wire logic [status_pin_pkg::NUM_SRC-1:0]     src_in,
	// Selected level
	output logic                                        level_out
);
	assign level_out = src_in[sel_in];
endmodule
`default_nettype wire

// ### verif/pin_observer.sv
// Board-side model that counts rising edges seen on the status pin.
`timescale 1ns/100ps
`default_nettype none
module pin_observer (
	// Clock, reset and pin
	input  wire logic        clk_sys_in,
	input  wire logic        nrst_in,
	input  wire logic        pin_in,
	// Edge count
	output logic      [15:0] edges_out
);
	logic last_q;
	// Sampling on the clock mirrors a synchronous receiver on the board.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			last_q    <= 1'b0;
			edges_out <= 16'h0000;
		end else begin
			last_q <= pin_in;
			if (pin_in && !last_q) edges_out <= edges_out + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ### verif/status_pin_source_select_monitor.sv
// Checker for the status pin block ports.
`timescale 1ns/100ps
`default_nettype none
module status_pin_check (
	// Clock, reset and register port
	input wire logic       clk_sys_in,
	input wire logic       nrst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Level sources and the pin
	input wire logic       primary_reference_input_los_in,
	input wire logic       secondary_reference_input_los_in,
	input wire logic       synthesizer_a_loss_of_lock_in,
	input wire logic       status_pin_b_out
);
	logic [7:0] ctl_q;
	logic       tst_en_q;
	logic       tst_val_q;
	wire logic [3:0] lv = {1'b0, synthesizer_a_loss_of_lock_in,
		secondary_reference_input_los_in, primary_reference_input_los_in};
	wire logic exp_w = lv[ctl_q[5:4]] ~^ ctl_q[3];
	wire logic mapped = reg_addr_in inside {8'h1c, 8'h40, 8'h44, 8'h48,
		8'h4c, 8'h50};
	// Shadow copies let the pin checks know the selection from outside.
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctl_q     <= 8'h28;
			tst_en_q  <= 1'b0;
			tst_val_q <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == 8'h1c) begin
			ctl_q <= reg_wdata_in;
		end else if (reg_wr_in && reg_addr_in == 8'h50) begin
			tst_en_q  <= reg_wdata_in[0];
			tst_val_q <= reg_wdata_in[1];
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	chk_rd_idle: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("stray data");
	chk_no_map: assert property (
		reg_rd_in && !mapped |=> reg_rdata_out == 8'h00) else $error("unmapped");
	chk_rsv_zero: assert property (
		reg_rd_in && reg_addr_in == 8'h1c |=> reg_rdata_out[2:0] == 3'h0)
		else $error("reserved bits set");
	chk_ctl_readback: assert property (
		reg_rd_in && reg_addr_in == 8'h1c |=> reg_rdata_out[7:3] == ctl_q[7:3])
		else $error("control readback wrong");
	chk_ref_los: assert property (
		!tst_en_q && ctl_q[7:5] == 3'h0 |=> status_pin_b_out == $past(exp_w))
		else $error("reference loss not shown");
	chk_lock_a: assert property (
		!tst_en_q && ctl_q[7:4] == 4'h2 |=> status_pin_b_out == $past(exp_w))
		else $error("lock loss not shown");
	chk_low_sense: assert property (
		!tst_en_q && ctl_q[7:3] == 5'h00 |=>
		status_pin_b_out == !$past(primary_reference_input_los_in))
		else $error("active low sense wrong");
	chk_test_over: assert property (
		tst_en_q |=> status_pin_b_out == $past(tst_val_q))
		else $error("test override ignored");
endmodule
bind status_pin_source_select status_pin_check u_chk (
	.clk_sys_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .primary_reference_input_los_in,
	.secondary_reference_input_los_in, .synthesizer_a_loss_of_lock_in,
	.status_pin_b_out);
`default_nettype wire

// ### verif/tb_status_pin_source_select.sv
// Self-checking bench for the status pin block.
`timescale 1ns/100ps
`default_nettype none
module tb_status_pin_source_select;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, fset = 8'h00;
	logic wr = 1'b0, rd = 1'b0, rnd_on = 1'b0, pin, irq;
	logic [8:0] lv = 9'h000;
	logic [5:0] pulse = 6'h00, byp = 6'h00, m_half;
	logic [7:0] m_flag, m_fmask;
	logic [1:0] m_tst;
	logic [15:0] edges, src;
	logic m_pin, m_st, m_mask0, m_last;
	int err_count = 0, tests_run = 0, m_ctl, m_kind, seed, m_rise;
	wire logic [5:0] tap = m_half & ~(byp & 6'h2d);
	always #12.5 clk_sys_in = ~clk_sys_in;
	status_pin_source_select u_dut (.clk_sys_in, .nrst_in,
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata),
		.primary_reference_input_los_in(lv[0]),
		.secondary_reference_input_los_in(lv[1]),
		.synthesizer_a_loss_of_lock_in(lv[2]),
		.synthesizer_b_loss_of_lock_in(lv[3]),
		.synthesizer_a_cal_in(lv[4]), .synthesizer_b_cal_in(lv[5]),
		.eeprom_active_in(lv[6]), .synthesizer_a_switch_in(lv[7]),
		.synthesizer_b_switch_in(lv[8]), .div_pulse_in(pulse),
		.div_bypass_in(byp), .int_flag_set_in(fset),
		.status_pin_b_out(pin), .irq_out(irq));
	pin_observer u_obs (.clk_sys_in, .nrst_in, .pin_in(pin), .edges_out(edges));
	// The model reads inputs as they stood before the edge, like the flops.
	always @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			m_ctl = 32'h28;
			m_rise = 0;
			m_last = 1'b0;
			{m_flag, m_fmask, m_tst, m_mask0, m_st, m_half, m_pin} = '0;
		end else begin
			// The board receiver sees the pin one flop later than the model.
			if (m_pin && !m_last) m_rise++;
			m_last = m_pin;
			src = {lv[8:6], tap[5], tap[2], |(m_flag & m_fmask), lv[5:4],
				tap[4:3], lv[3], tap[1:0], lv[2:0]};
			m_kind = m_tst[0] ? 2 : (m_ctl[7:4] < 8 ? 0 : 1);
			m_pin = m_tst[0] ? m_tst[1] : src[m_ctl[7:4]] ~^ m_ctl[3];
			m_half = m_half ^ pulse;
			if (wr && addr == 8'h48) m_flag = m_flag & ~wdata;
			m_flag = m_flag | fset;
			if (wr && addr == 8'h1c) m_ctl = wdata;
			if (wr && addr == 8'h1c) m_st = 1'b1;
			if (wr && addr == 8'h40 && wdata[0]) m_st = 1'b0;
			if (wr && addr == 8'h44) m_mask0 = wdata[0];
			if (wr && addr == 8'h4c) m_fmask = wdata;
			if (wr && addr == 8'h50) m_tst = wdata[1:0];
		end
	end
	always @(posedge clk_sys_in) if (rnd_on) begin
		lv <= 9'($urandom);
		pulse <= 6'($urandom & $urandom);
		fset <= 8'($urandom & $urandom & $urandom);
	end
	always @(negedge clk_sys_in) if (nrst_in === 1'b1) begin
		cmp({7'h0, irq}, {7'h0, m_st & m_mask0});
		cmp(edges[7:0], 8'(m_rise));
		if (m_kind == 2) cmp({7'h0, pin}, {7'h0, m_pin});
		else if (m_kind == 0) cmp({7'h0, pin}, {7'h0, m_pin});
		else cmp({7'h0, pin}, {7'h0, m_pin});
	end
	task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		@(negedge clk_sys_in);
		cmp(rdata, e);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		err_count++;
		end_of_test;
	end
	initial begin
		seed = $urandom(32'hecb4);
		repeat (8) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		rd_reg(8'h1c, 8'h28);
		rd_reg(8'h33, 8'h00);
		wr_reg(8'h4c, 8'hff);
		rnd_on <= 1'b1;
		for (int c = 0; c < 32; c++) begin
			byp <= 6'($urandom);
			wr_reg(8'h1c, {c[4:1], c[0], 3'h7});
			rd_reg(8'h1c, {c[4:1], c[0], 3'h0});
			repeat (12) @(posedge clk_sys_in);
			if (c[4:1] == 4'ha) wr_reg(8'h48, 8'hff);
		end
		wr_reg(8'h50, 8'h03);
		repeat (4) @(posedge clk_sys_in);
		wr_reg(8'h50, 8'h01);
		repeat (4) @(posedge clk_sys_in);
		wr_reg(8'h50, 8'h00);
		wr_reg(8'h44, 8'h01);
		wr_reg(8'h44, 8'h00);
		wr_reg(8'h44, 8'h01);
		wr_reg(8'h40, 8'h01);
		rd_reg(8'h44, 8'h01);
		rd_reg(8'h4c, 8'hff);
		rd_reg(8'h50, 8'h00);
		repeat (4) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		cmp({7'h0, edges == 16'h0000}, 8'h00);
		end_of_test;
	end
endmodule
`default_nettype wire
